// ===== core/option_byte_config_decode.sv
// Configuration byte decoder with APB control and status
// Behaviour
// - Config bytes have no processor address; access only in programming mode.
// - Erased configuration bytes read as all ones, FFh.
// - Mask-programmed parts use fixed values; programming cannot change them.
// - Byte0 bit7 set: entering halt with watchdog running causes reset.
// - Byte0 bit6 clear: hardware watchdog always on; set: software enables it.
// - Byte0 bits4:3 pick detector threshold; 11 turns both detectors off.
// - Byte0 bit0 clear enables readout and write protection of program memory.
// - Erasing bytes while protected first wipes all user memory.
// - Byte1 bit7 selects 44-pin package when set, 32-pin when clear.
// - Unbonded pads leave reset as pulled-up inputs.
// - Byte1 bit6 selects 4096 or 256 reset-phase cycles, also after halt.
// - Byte1 bits5:4: resonator, reserved, internal RC, external clock.
// - Byte1 bits3:1 select resonator drive range 1-2 up to 8-16 MHz.
// - External clock forces the medium power 2-4 MHz range setting.
// - Parts ship configured for the internal RC clock source.
`timescale 1ns/1ns
module option_byte_config_decode #(
  parameter bit MASK_ROM = 1'b0
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [7:0]               i_opt_byte0,
  input  wire logic [7:0]               i_opt_byte1,
  input  wire logic                     i_prog_mode,
  input  wire optcfg_pkg::prog_req_type i_prog_req,
  input  wire logic                     i_user_erase_done,
  input  wire logic                     i_halt_enter,
  input  wire logic                     i_halt_exit,
  output logic                          o_prog_ack,
  output logic [7:0]                    o_prog_rdata,
  output logic                          o_nv_we,
  output logic                          o_nv_sel,
  output logic [7:0]                    o_nv_wdata,
  output logic                          o_user_erase,
  output optcfg_pkg::settings_type      o_settings,
  output logic                          o_watchdog_enable,
  output logic                          o_halt_reset,
  output logic                          o_reset_phase_active,
  output logic                          o_memory_protect,
  output logic                          o_unbonded_pullup
);

  // Hard-wired parts ignore the array contents entirely
  wire logic [7:0] byte0 = MASK_ROM ? optcfg_pkg::ROM_BYTE0 : i_opt_byte0;
  wire logic [7:0] byte1 = MASK_ROM ? optcfg_pkg::ROM_BYTE1 : i_opt_byte1;

  optcfg_pkg::settings_type decoded;

  option_field_decode u_decode (
    .i_byte0    (byte0),
    .i_byte1    (byte1),
    .o_settings (decoded)
  );

  option_prog_port #(
    .MASK_ROM (MASK_ROM)
  ) u_prog (
    .i_ref_clk         (i_ref_clk),
    .i_reset           (i_reset),
    .i_prog_mode       (i_prog_mode),
    .i_req             (i_prog_req),
    .i_byte0           (byte0),
    .i_byte1           (byte1),
    .i_user_erase_done (i_user_erase_done),
    .o_ack             (o_prog_ack),
    .o_rdata           (o_prog_rdata),
    .o_nv_we           (o_nv_we),
    .o_nv_sel          (o_nv_sel),
    .o_nv_wdata        (o_nv_wdata),
    .o_user_erase      (o_user_erase)
  );

  // Capture once after reset release; later programming waits for a reset
  logic captured;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      captured <= 1'b0;
    else
      captured <= 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_settings <= '0;
    else if (!captured)
      o_settings <= decoded;
  end

  // Settings used before capture come straight from the bytes
  wire optcfg_pkg::settings_type live = captured ? o_settings : decoded;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_memory_protect  <= 1'b0;
      o_unbonded_pullup <= 1'b1;
    end
    else
    begin
      o_memory_protect  <= live.protect;
      o_unbonded_pullup <= ~live.pkg44;
    end
  end

  // APB: one wait state so read data comes from a flop
  logic ctrl_wdg_en;

  wire logic        access    = psel && penable;
  wire logic        complete  = access && pready;
  wire logic        hit_ctrl  = (paddr == optcfg_pkg::ADDR_CTRL);
  wire logic        hit_stat  = (paddr == optcfg_pkg::ADDR_STATUS);
  wire logic        mapped    = hit_ctrl || hit_stat;
  wire logic        bad_write = pwrite && hit_stat;
  wire logic [31:0] ctrl_word = {31'h0, ctrl_wdg_en};
  wire logic [31:0] stat_word = {16'h0, o_reset_phase_active, o_settings};
  wire logic [31:0] read_word = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (access && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0 : read_word;
      pslverr <= !mapped || bad_write;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software enable is sticky; only reset turns the watchdog back off
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      ctrl_wdg_en <= 1'b0;
    else if (complete && pwrite && hit_ctrl && pwdata[optcfg_pkg::CTRL_WDG_EN])
      ctrl_wdg_en <= 1'b1;
  end

  wire logic wdg_active = live.hw_watchdog || ctrl_wdg_en;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_watchdog_enable <= 1'b0;
      o_halt_reset      <= 1'b0;
    end
    else
    begin
      o_watchdog_enable <= wdg_active;
      o_halt_reset      <= i_halt_enter && wdg_active && live.halt_reset;
    end
  end

  // Reset phase counter, restarted on halt exit
  logic [12:0] phase_cnt;

  wire logic [12:0] phase_len  = live.short_phase ? optcfg_pkg::SHORT_PHASE
                                                  : optcfg_pkg::LONG_PHASE;
  wire logic        phase_last = (phase_cnt == phase_len - 13'h0001);

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      phase_cnt            <= 13'h0000;
      o_reset_phase_active <= 1'b1;
    end
    else if (i_halt_exit && !o_reset_phase_active)
    begin
      phase_cnt            <= 13'h0000;
      o_reset_phase_active <= 1'b1;
    end
    else if (o_reset_phase_active)
    begin
      phase_cnt            <= phase_last ? 13'h0000 : phase_cnt + 13'h0001;
      o_reset_phase_active <= !phase_last;
    end
  end

  // Helper for checking phase length
  logic [12:0] phase_seen;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      phase_seen <= 13'h0001;
    // Restart at one so a halt-exit phase counts like the reset phase
    else if (!o_reset_phase_active)
      phase_seen <= 13'h0001;
    else
      phase_seen <= phase_seen + 13'h0001;
  end

  a_halt_reset_fire: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (captured && i_halt_enter && wdg_active && o_settings.halt_reset) |=> o_halt_reset)
    else $error("Halt with watchdog did not reset");
  a_halt_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (captured && !o_settings.halt_reset) |=> !o_halt_reset)
    else $error("Halt reset without option");
  a_hw_watchdog_on: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (captured && o_settings.hw_watchdog) |=> o_watchdog_enable)
    else $error("Hardware watchdog not enabled");
  a_detector_off: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (captured && o_settings.vd_threshold == 2'h3) |-> (!o_settings.lvd_en && !o_settings.avd_en))
    else $error("Detectors left on with threshold off");
  a_ext_medium_range: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (captured && o_settings.source == 2'h3) |-> (o_settings.range == 3'h1))
    else $error("External clock without medium range");
  a_settings_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    captured |=> $stable(o_settings))
    else $error("Settings changed after capture");
  a_phase_length: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $fell(o_reset_phase_active) |->
      ($past(phase_seen) == (o_settings.short_phase ? 13'h0100 : 13'h1000)))
    else $error("Reset phase length wrong");
  a_protect_follow: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    captured |=> (o_memory_protect == o_settings.protect))
    else $error("Protection output does not follow option");
  a_apb_one_wait: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (access && !pready) |=> (pready ##1 !pready))
    else $error("APB answer timing wrong");

endmodule : option_byte_config_decode

// ===== common/optcfg_pkg.sv
// Constants and carriers for the configuration byte decoder
package optcfg_pkg;

  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [7:0]  ROM_BYTE0      = 8'he7;
  localparam logic [7:0]  ROM_BYTE1      = 8'he5;

  localparam int          B0_HALT_RST    = 7;
  localparam int          B0_WDG_TYPE    = 6;
  localparam int          B0_VD_LSB      = 3;
  localparam int          B0_PROTECT     = 0;
  localparam int          B1_PKG         = 7;
  localparam int          B1_RESET_CYCLE_SELECT        = 6;
  localparam int          B1_SRC_LSB     = 4;
  localparam int          B1_RANGE_LSB   = 1;
  localparam int          B1_PLL_OFF     = 0;

  localparam logic [1:0]  SRC_RESONATOR  = 2'h0;
  localparam logic [1:0]  SRC_INTERNAL   = 2'h2;
  localparam logic [1:0]  SRC_EXTERNAL   = 2'h3;
  localparam logic [2:0]  RANGE_MEDIUM   = 3'h1;
  localparam logic [1:0]  VD_OFF         = 2'h3;

  localparam logic [12:0] LONG_PHASE     = 13'h1000;
  localparam logic [12:0] SHORT_PHASE    = 13'h0100;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam int          CTRL_WDG_EN    = 0;

  localparam logic [1:0]  PCMD_READ      = 2'h0;
  localparam logic [1:0]  PCMD_WRITE     = 2'h1;
  localparam logic [1:0]  PCMD_ERASE     = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [1:0] cmd;
    logic       sel;
    logic [7:0] wdata;
  } prog_req_type;

  typedef struct packed {
    logic       halt_reset;
    logic       hw_watchdog;
    logic [1:0] vd_threshold;
    logic       lvd_en;
    logic       avd_en;
    logic       protect;
    logic       pkg44;
    logic       short_phase;
    logic [1:0] source;
    logic [2:0] range;
    logic       pll_en;
  } settings_type;

endpackage : optcfg_pkg

// ===== core/option_field_decode.sv
// Field decoder from the two configuration bytes to settings
`timescale 1ns/1ns
module option_field_decode (
  input  wire logic [7:0]                 i_byte0,
  input  wire logic [7:0]                 i_byte1,
  output optcfg_pkg::settings_type        o_settings
);

  wire logic [1:0] vd  = i_byte0[optcfg_pkg::B0_VD_LSB +: 2];
  wire logic [1:0] src = i_byte1[optcfg_pkg::B1_SRC_LSB +: 2];
  wire logic       ext = (src == optcfg_pkg::SRC_EXTERNAL);

  assign o_settings.halt_reset   = i_byte0[optcfg_pkg::B0_HALT_RST];
  assign o_settings.hw_watchdog  = ~i_byte0[optcfg_pkg::B0_WDG_TYPE];
  assign o_settings.vd_threshold = vd;
  assign o_settings.lvd_en       = (vd != optcfg_pkg::VD_OFF);
  assign o_settings.avd_en       = (vd != optcfg_pkg::VD_OFF);
  assign o_settings.protect      = ~i_byte0[optcfg_pkg::B0_PROTECT];
  assign o_settings.pkg44        = i_byte1[optcfg_pkg::B1_PKG];
  assign o_settings.short_phase  = i_byte1[optcfg_pkg::B1_RESET_CYCLE_SELECT];
  assign o_settings.source       = src;
  // External clock forces medium drive whatever the field holds
  assign o_settings.range        = ext ? optcfg_pkg::RANGE_MEDIUM
                                       : i_byte1[optcfg_pkg::B1_RANGE_LSB +: 3];
  assign o_settings.pll_en       = ~i_byte1[optcfg_pkg::B1_PLL_OFF];

endmodule : option_field_decode

// ===== core/option_prog_port.sv
// Programming-mode access port for the configuration bytes
`timescale 1ns/1ns
module option_prog_port #(
  parameter bit MASK_ROM = 1'b0
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset,
  input  wire logic                     i_prog_mode,
  input  wire optcfg_pkg::prog_req_type i_req,
  input  wire logic [7:0]               i_byte0,
  input  wire logic [7:0]               i_byte1,
  input  wire logic                     i_user_erase_done,
  output logic                          o_ack,
  output logic [7:0]                    o_rdata,
  output logic                          o_nv_we,
  output logic                          o_nv_sel,
  output logic [7:0]                    o_nv_wdata,
  output logic                          o_user_erase
);

  typedef enum logic [1:0] {ST_IDLE, ST_WIPE, ST_CLR0, ST_CLR1} state_type;
  state_type state;

  wire logic take      = i_prog_mode && i_req.valid && (state == ST_IDLE);
  wire logic is_write  = take && (i_req.cmd == optcfg_pkg::PCMD_WRITE);
  wire logic is_erase  = take && (i_req.cmd == optcfg_pkg::PCMD_ERASE);
  wire logic protected_now = ~i_byte0[optcfg_pkg::B0_PROTECT];

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state        <= ST_IDLE;
      o_ack        <= 1'b0;
      o_rdata      <= 8'h00;
      o_nv_we      <= 1'b0;
      o_nv_sel     <= 1'b0;
      o_nv_wdata   <= 8'h00;
      o_user_erase <= 1'b0;
    end
    else
    begin
      o_ack        <= 1'b0;
      o_nv_we      <= 1'b0;
      o_user_erase <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (take && i_req.cmd == optcfg_pkg::PCMD_READ)
          begin
            o_ack   <= 1'b1;
            o_rdata <= i_req.sel ? i_byte1 : i_byte0;
          end
          // Hard-wired parts accept the command but change nothing
          else if (MASK_ROM && (is_write || is_erase))
            o_ack <= 1'b1;
          else if (is_write)
          begin
            o_ack      <= 1'b1;
            o_nv_we    <= 1'b1;
            o_nv_sel   <= i_req.sel;
            o_nv_wdata <= i_req.wdata;
          end
          else if (is_erase && protected_now)
          begin
            o_user_erase <= 1'b1;
            state        <= ST_WIPE;
          end
          else if (is_erase)
            state <= ST_CLR0;
        end
        ST_WIPE:
          if (i_user_erase_done)
            state <= ST_CLR0;
        ST_CLR0:
        begin
          o_nv_we    <= 1'b1;
          o_nv_sel   <= 1'b0;
          o_nv_wdata <= optcfg_pkg::ERASED_BYTE;
          state      <= ST_CLR1;
        end
        ST_CLR1:
        begin
          o_nv_we    <= 1'b1;
          o_nv_sel   <= 1'b1;
          o_nv_wdata <= optcfg_pkg::ERASED_BYTE;
          o_ack      <= 1'b1;
          state      <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  a_prog_mode_gate: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!i_prog_mode && state == ST_IDLE) |=> (!o_ack && !o_nv_we))
    else $error("Config bytes touched outside programming mode");
  a_wipe_before_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (is_erase && protected_now && !MASK_ROM) |=> (o_user_erase && !o_nv_we)
      ##1 (state == ST_WIPE || state == ST_CLR0))
    else $error("Protected erase skipped user memory wipe");
  a_erase_ones: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state == ST_CLR1) |=> (o_nv_we && o_nv_wdata == 8'hff && o_ack))
    else $error("Erase did not write all ones");
  a_rom_locked: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    MASK_ROM |-> !o_nv_we)
    else $error("Hard-wired option changed");

endmodule : option_prog_port

// ===== verif/nv_store_model.sv
// Non-volatile byte store and wipe engine on the programming side
`timescale 1ns/1ns
module nv_store_model #(
  parameter int WIPE_CYCLES = 40
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_nv_we,
  input  wire logic       i_nv_sel,
  input  wire logic [7:0] i_nv_wdata,
  input  wire logic       i_user_erase,
  output logic [7:0]      o_byte0,
  output logic [7:0]      o_byte1,
  output logic            o_wipe_done
);
  int wipe_cnt;

  initial
  begin
    o_byte0 = 8'he7;
    // Shipped with internal RC source selected
    o_byte1 = 8'he7;
    o_wipe_done = 1'b0;
    wipe_cnt = 0;
  end

  always @(posedge i_ref_clk)
  begin
    o_wipe_done <= 1'b0;
    if (i_nv_we === 1'b1 && i_nv_sel === 1'b0)
      o_byte0 <= i_nv_wdata;
    if (i_nv_we === 1'b1 && i_nv_sel === 1'b1)
      o_byte1 <= i_nv_wdata;
    // Slow wipe so a premature byte write shows up
    if (i_user_erase === 1'b1)
      wipe_cnt <= WIPE_CYCLES;
    else if (wipe_cnt == 1)
    begin
      wipe_cnt <= 0;
      o_wipe_done <= 1'b1;
    end
    else if (wipe_cnt > 1)
      wipe_cnt <= wipe_cnt - 1;
  end
endmodule : nv_store_model

// ===== verif/testbench.sv
// Self-checking bench for the configuration byte decoder
`timescale 1ns/1ns
module testbench;
  logic i_ref_clk, i_reset, psel, penable, pwrite, pready, pslverr, err, wiping;
  logic [7:0] paddr, nv_b0, nv_b1, o_prog_rdata, o_nv_wdata, pb;
  logic [31:0] pwdata, prdata, rd;
  logic i_prog_mode, i_halt_enter, i_halt_exit, wipe_done, o_prog_ack, o_nv_we;
  logic o_nv_sel, o_user_erase, o_watchdog_enable, o_halt_reset, o_reset_phase_active;
  logic o_memory_protect, o_unbonded_pullup, rom_we;
  optcfg_pkg::prog_req_type i_prog_req;
  optcfg_pkg::settings_type o_settings, snap, rom_set;
  int n_fail, checked, cyc, n_ack, n_we, n_halt, n_wipe, n_bad, n_rom, i, h, n;
  // Reserved byte0 bits kept at one; doubler only with medium range
  logic [7:0] tab0 [4] = '{8'he7, 8'hef, 8'hf7, 8'hff};
  logic [7:0] tab1 [4] = '{8'h81, 8'h52, 8'he5, 8'hb7};
  logic [7:0] hb0 [3] = '{8'ha7, 8'h27, 8'he7};
  int hexp [3] = '{1, 0, 0};

  option_byte_config_decode #(.MASK_ROM(1'b0)) u_option_byte_config_decode (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_opt_byte0(nv_b0), .i_opt_byte1(nv_b1), .i_prog_mode(i_prog_mode),
    .i_prog_req(i_prog_req), .i_user_erase_done(wipe_done), .i_halt_enter(i_halt_enter),
    .i_halt_exit(i_halt_exit), .o_prog_ack(o_prog_ack), .o_prog_rdata(o_prog_rdata),
    .o_nv_we(o_nv_we), .o_nv_sel(o_nv_sel), .o_nv_wdata(o_nv_wdata),
    .o_user_erase(o_user_erase), .o_settings(o_settings),
    .o_watchdog_enable(o_watchdog_enable), .o_halt_reset(o_halt_reset),
    .o_reset_phase_active(o_reset_phase_active), .o_memory_protect(o_memory_protect),
    .o_unbonded_pullup(o_unbonded_pullup));

  nv_store_model u_nv_store_model (
    .i_ref_clk(i_ref_clk), .i_nv_we(o_nv_we), .i_nv_sel(o_nv_sel),
    .i_nv_wdata(o_nv_wdata), .i_user_erase(o_user_erase), .o_byte0(nv_b0),
    .o_byte1(nv_b1), .o_wipe_done(wipe_done));

  // Hard-wired variant on the same programming traffic
  option_byte_config_decode #(.MASK_ROM(1'b1)) u_option_byte_config_decode_rom (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
    .paddr(8'h00), .pwdata(32'h0), .prdata(), .pready(), .pslverr(), .i_opt_byte0(nv_b0),
    .i_opt_byte1(nv_b1), .i_prog_mode(i_prog_mode), .i_prog_req(i_prog_req),
    .i_user_erase_done(wipe_done), .i_halt_enter(i_halt_enter), .i_halt_exit(i_halt_exit),
    .o_prog_ack(), .o_prog_rdata(), .o_nv_we(rom_we), .o_nv_sel(), .o_nv_wdata(),
    .o_user_erase(), .o_settings(rom_set), .o_watchdog_enable(), .o_halt_reset(),
    .o_reset_phase_active(), .o_memory_protect(), .o_unbonded_pullup());

  initial i_ref_clk = 1'b0;
  always #5 i_ref_clk = ~i_ref_clk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (o_prog_ack === 1'b1) n_ack <= n_ack + 1;
    if (o_nv_we === 1'b1) n_we <= n_we + 1;
    if (o_halt_reset === 1'b1) n_halt <= n_halt + 1;
    if (o_user_erase === 1'b1) n_wipe <= n_wipe + 1;
    if (rom_we === 1'b1) n_rom <= n_rom + 1;
    if (o_user_erase === 1'b1) wiping <= 1'b1;
    else if (wipe_done) wiping <= 1'b0;
    if (o_nv_we === 1'b1 && wiping) n_bad <= n_bad + 1;
    if (cyc == 90000)
    begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic optcfg_pkg::settings_type exp_set(input logic [7:0] b0, b1);
    optcfg_pkg::settings_type s;
    s.halt_reset = b0[7];
    s.hw_watchdog = ~b0[6];
    s.vd_threshold = b0[4:3];
    s.lvd_en = (b0[4:3] != 2'h3);
    s.avd_en = (b0[4:3] != 2'h3);
    s.protect = ~b0[0];
    s.pkg44 = b1[7];
    s.short_phase = b1[6];
    s.source = b1[5:4];
    s.range = (b1[5:4] == 2'h3) ? 3'h1 : b1[3:1];
    s.pll_en = ~b1[0];
    return s;
  endfunction : exp_set

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    // Only the bench timeout ends this wait
    do
      @(posedge i_ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic prog(input logic [1:0] cmd, input logic sel, input logic [7:0] wd);
    int k;
    @(posedge i_ref_clk);
    i_prog_req <= '{1'b1, cmd, sel, wd};
    @(posedge i_ref_clk);
    i_prog_req.valid <= 1'b0;
    for (k = 0; k < 200; k++)
    begin
      @(posedge i_ref_clk);
      if (o_prog_ack === 1'b1) break;
    end
    pb = o_prog_rdata;
    // Let the store take the last write before anyone looks
    @(posedge i_ref_clk);
  endtask : prog

  // Leading idle cycles skipped, since a halt exit restarts the phase late
  task automatic phase_len;
    int k;
    logic [12:0] e;
    e = nv_b1[6] ? optcfg_pkg::SHORT_PHASE : optcfg_pkg::LONG_PHASE;
    n = 0;
    for (k = 0; k < 5000; k++)
    begin
      @(posedge i_ref_clk);
      if (o_reset_phase_active === 1'b1) n++;
      else if (n > 0) break;
    end
    chk("phase_len", (n >= e) && (n <= e + 2), 1);
  endtask : phase_len

  task automatic do_reset;
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    chk("phase_rst", o_reset_phase_active, 1);
    chk("pullup_rst", o_unbonded_pullup, 1);
    i_reset <= 1'b0;
    phase_len();
    chk("settings", o_settings, exp_set(nv_b0, nv_b1));
    chk("pullup", o_unbonded_pullup, {~nv_b1[7]});
  endtask : do_reset

  task automatic pulse(input logic ex);
    @(posedge i_ref_clk);
    if (ex)
      i_halt_exit <= 1'b1;
    else
      i_halt_enter <= 1'b1;
    @(posedge i_ref_clk);
    i_halt_exit <= 1'b0;
    i_halt_enter <= 1'b0;
  endtask : pulse

  initial
  begin
    i_reset = 1'b1;
    {psel, penable, pwrite, i_prog_mode, i_halt_enter, i_halt_exit, wiping} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    i_prog_req = '0;
    {n_fail, checked, cyc, n_ack, n_we, n_halt, n_wipe, n_bad, n_rom} = '0;
    do_reset();
    chk("ship_src", o_settings.source, optcfg_pkg::SRC_INTERNAL);
    apb(1'b0, optcfg_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, {17'h0, exp_set(nv_b0, nv_b1)});
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped", err, 1);
    apb(1'b1, optcfg_pkg::ADDR_STATUS, 32'h0);
    chk("ro_status", err, 1);
    h = n_ack;
    prog(optcfg_pkg::PCMD_WRITE, 1'b0, 8'h00);
    chk("unmoded", n_ack + n_we - h, 0);
    chk("unmoded_b0", nv_b0, 8'he7);
    i_prog_mode <= 1'b1;
    prog(optcfg_pkg::PCMD_READ, 1'b1, 8'h00);
    chk("rd_b1", pb, nv_b1);
    for (i = 0; i < 4; i++)
    begin
      snap = o_settings;
      prog(optcfg_pkg::PCMD_WRITE, 1'b0, tab0[i]);
      prog(optcfg_pkg::PCMD_WRITE, 1'b1, tab1[i]);
      chk("nv_b0", nv_b0, tab0[i]);
      chk("nv_b1", nv_b1, tab1[i]);
      chk("held", o_settings, snap);
      do_reset();
      apb(1'b0, optcfg_pkg::ADDR_STATUS, 32'h0);
      chk("status_tab", rd, {17'h0, exp_set(tab0[i], tab1[i])});
      chk("rom_set", rom_set, exp_set(optcfg_pkg::ROM_BYTE0, optcfg_pkg::ROM_BYTE1));
    end
    for (i = 0; i < 3; i++)
    begin
      prog(optcfg_pkg::PCMD_WRITE, 1'b0, hb0[i]);
      do_reset();
      chk("wdg_en", o_watchdog_enable, {~hb0[i][6]});
      h = n_halt;
      pulse(1'b0);
      repeat (4) @(posedge i_ref_clk);
      chk("halt_rst", n_halt - h, hexp[i]);
    end
    apb(1'b1, optcfg_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, optcfg_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl_rd", rd[0], 1);
    chk("sw_wdg_en", o_watchdog_enable, 1);
    h = n_halt;
    pulse(1'b0);
    repeat (4) @(posedge i_ref_clk);
    chk("halt_rst_sw", n_halt - h, 1);
    pulse(1'b1);
    phase_len();
    prog(optcfg_pkg::PCMD_WRITE, 1'b0, 8'he6);
    do_reset();
    chk("protect", o_memory_protect, 1);
    h = n_wipe;
    prog(optcfg_pkg::PCMD_ERASE, 1'b0, 8'h00);
    chk("wipe", n_wipe - h, 1);
    chk("wipe_order", n_bad, 0);
    chk("erased_b0", nv_b0, optcfg_pkg::ERASED_BYTE);
    chk("erased_b1", nv_b1, optcfg_pkg::ERASED_BYTE);
    do_reset();
    chk("unprotect", o_memory_protect, 0);
    h = n_wipe;
    prog(optcfg_pkg::PCMD_ERASE, 1'b0, 8'h00);
    repeat (2) @(posedge i_ref_clk);
    chk("no_wipe", n_wipe - h, 0);
    chk("rom_locked", n_rom, 0);
    tally_and_finish();
  end
endmodule : testbench
